//--- design/bfm_ball_mux.sv
// ball function multiplexer: routes internal functions onto shared balls
`timescale 1ns/1ps
`default_nettype none
module bfm_ball_mux (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// configuration
	input wire logic [31:0] ball_function_select_reg,
	input wire logic pullup_wr_en,
	input wire logic [bfm_pkg::NUM_GPIO-1:0] pullup_wr_data,
	output logic [bfm_pkg::NUM_GPIO-1:0] pullup_en,
	output logic fast_bus_monitor_strap,
	// balls
	input wire logic [bfm_pkg::NUM_BALLS-1:0] ball_in,
	output logic [bfm_pkg::NUM_BALLS-1:0] ball_out,
	output logic [bfm_pkg::NUM_BALLS-1:0] ball_oe,
	// isa and chip selects, asserted high
	input wire logic isa_io_write_strobe,
	input wire logic flash_disk_write_strobe,
	input wire logic flash_disk_chip_select,
	input wire logic io_chip_select_zero,
	// general purpose io
	input wire logic [bfm_pkg::NUM_GPIO-1:0] general_io_out,
	input wire logic [bfm_pkg::NUM_GPIO-1:0] general_io_oe,
	output logic [bfm_pkg::NUM_GPIO-1:0] general_io_in,
	// flat panel and video out
	input wire logic [17:0] flat_panel_data,
	input wire logic flat_panel_data_clock,
	input wire logic [7:0] video_out_port_data,
	input wire logic video_out_port_clock,
	// fast bus monitor, asserted high
	input wire logic [7:0] monitor_addr_data,
	input wire logic [3:0] monitor_byte_enable,
	input wire logic monitor_initiator_ready,
	input wire logic monitor_bus_clock,
	input wire logic monitor_sys_mgmt_irq_out,
	// printer port, asserted high
	input wire logic [1:0] printer_data_out,
	input wire logic printer_data_oe,
	output logic [1:0] printer_data_in,
	output logic printer_busy_in,
	output logic printer_ack_in,
	input wire logic printer_select_in_out,
	input wire logic printer_init_out,
	// serial port 2, disk channel 1 and test
	output logic uart2_set_ready_in,
	output logic disk_chan1_ready_in,
	input wire logic sdram_test_out_one,
	// cycle multiplexed pci / isa data bit
	input wire logic bus_phase_pci,
	input wire logic pci_ad_out,
	input wire logic pci_ad_oe,
	output logic pci_ad_in,
	input wire logic isa_data_out,
	input wire logic isa_data_oe,
	output logic isa_data_in,
	// pci clock 0 driven out on the strap ball
	input wire logic pci_clock_out_zero
);
	localparam int unsigned NB = bfm_pkg::NUM_BALLS;

	logic [NB-1:0] sync1_q; // first synchroniser stage
	logic [NB-1:0] sync2_q; // second stage, the only one logic reads
	logic strap_q; // captured monitor strap
	logic [bfm_pkg::NUM_GPIO-1:0] pullup_q; // gpio pull-up enables
	logic [NB-1:0] out_d; // next ball level
	logic [NB-1:0] oe_d; // next ball drive enable
	logic [NB-1:0] out_q;
	logic [NB-1:0] oe_q;
	logic [bfm_pkg::NUM_GPIO-1:0] gpio_in_d;
	logic [1:0] pd_in_d;
	logic busy_d, ack_d, dsr_d, iordy_d;
	logic pci_in_d, isa_in_d;
	logic [bfm_pkg::NUM_GPIO-1:0] gpio_in_q;
	logic [1:0] pd_in_q;
	logic busy_q, ack_q, dsr_q, iordy_q;
	logic pci_in_q, isa_in_q;
	logic monitor_sel; // monitor requested by bit or strap
	logic panel_sel; // panel owns shared chip select balls
	bfm_pkg::bfm_group_type grp; // owner of the printer ball group
	logic [1:0] strobe_sel; // bits 21,2
	logic [1:0] uart_sel; // bits 18,8

	// every ball input passes two flops; they come from the board
	always_ff @(posedge mclk) begin
		sync1_q <= ball_in;
		sync2_q <= sync1_q;
	end

	// strap follows the ball while reset is held, frozen at release;
	// reset must last three edges so the synchroniser has settled
	always_ff @(posedge mclk) begin
		if (reset) begin
			strap_q <= sync2_q[bfm_pkg::BALL_PCI_CLOCK_OUT_ZERO];
		end
	end

	// pull-ups come up enabled, software may turn them off later
	always_ff @(posedge mclk) begin
		if (reset) begin
			pullup_q <= bfm_pkg::PULLUP_RESET;
		end else if (pullup_wr_en) begin
			pullup_q <= pullup_wr_data;
		end
	end

	// decode of the select bits, static configuration
	always_comb begin
		monitor_sel = ball_function_select_reg[bfm_pkg::SEL_MONITOR]
			| strap_q;
		panel_sel = ball_function_select_reg[bfm_pkg::SEL_FLAT_PANEL]
			& ~ball_function_select_reg[bfm_pkg::SEL_VIDEO_OUT];
		strobe_sel = {ball_function_select_reg[bfm_pkg::SEL_GPIO_STROBE],
			ball_function_select_reg[bfm_pkg::SEL_FLASH_STROBE]};
		uart_sel = {ball_function_select_reg[bfm_pkg::SEL_UART2],
			ball_function_select_reg[bfm_pkg::SEL_DISK_CHAN1]};
		// panel bit wins over the monitor request: the monitor needs it low
		if (ball_function_select_reg[bfm_pkg::SEL_FLAT_PANEL]) begin
			if (ball_function_select_reg[bfm_pkg::SEL_VIDEO_OUT]) begin
				grp = bfm_pkg::GRP_VIDEO;
			end else begin
				grp = bfm_pkg::GRP_PANEL;
			end
		end else if (monitor_sel) begin
			grp = bfm_pkg::GRP_MONITOR;
		end else begin
			grp = bfm_pkg::GRP_PRINTER;
		end
	end

	// ball drive: low-active functions are inverted at the ball
	always_comb begin
		out_d = '0;
		oe_d = '0;
		gpio_in_d = '0;
		pd_in_d = '0;
		busy_d = 1'b0;
		ack_d = 1'b0;
		dsr_d = 1'b0;
		iordy_d = 1'b0;
		// write strobe ball
		case (strobe_sel)
			2'h0: begin
				out_d[bfm_pkg::BALL_WR_STROBE] = ~isa_io_write_strobe;
				oe_d[bfm_pkg::BALL_WR_STROBE] = 1'b1;
			end
			2'h1: begin
				out_d[bfm_pkg::BALL_WR_STROBE] = ~flash_disk_write_strobe;
				oe_d[bfm_pkg::BALL_WR_STROBE] = 1'b1;
			end
			2'h3: begin
				out_d[bfm_pkg::BALL_WR_STROBE] =
					general_io_out[bfm_pkg::GPIO_FIFTEEN];
				oe_d[bfm_pkg::BALL_WR_STROBE] =
					general_io_oe[bfm_pkg::GPIO_FIFTEEN];
				gpio_in_d[bfm_pkg::GPIO_FIFTEEN] =
					sync2_q[bfm_pkg::BALL_WR_STROBE];
			end
			default: begin
				// undefined code: ball released, nothing routed
				oe_d[bfm_pkg::BALL_WR_STROBE] = 1'b0;
			end
		endcase
		// flash chip select ball
		if (panel_sel) begin
			out_d[bfm_pkg::BALL_FLASH_CS] = flat_panel_data[0];
			oe_d[bfm_pkg::BALL_FLASH_CS] = 1'b1;
		end else if (ball_function_select_reg[bfm_pkg::SEL_FLASH_CS]) begin
			out_d[bfm_pkg::BALL_FLASH_CS] = ~flash_disk_chip_select;
			oe_d[bfm_pkg::BALL_FLASH_CS] = 1'b1;
		end else begin
			out_d[bfm_pkg::BALL_FLASH_CS] =
				general_io_out[bfm_pkg::GPIO_TWENTY];
			oe_d[bfm_pkg::BALL_FLASH_CS] = general_io_oe[bfm_pkg::GPIO_TWENTY];
			gpio_in_d[bfm_pkg::GPIO_TWENTY] = sync2_q[bfm_pkg::BALL_FLASH_CS];
		end
		// io chip select 0 ball
		if (panel_sel) begin
			out_d[bfm_pkg::BALL_IO_CHIP_SELECT_ZERO] = flat_panel_data_clock;
			oe_d[bfm_pkg::BALL_IO_CHIP_SELECT_ZERO] = 1'b1;
		end else if (ball_function_select_reg[bfm_pkg::SEL_IO_CHIP_SELECT_ZERO]) begin
			out_d[bfm_pkg::BALL_IO_CHIP_SELECT_ZERO] = ~io_chip_select_zero;
			oe_d[bfm_pkg::BALL_IO_CHIP_SELECT_ZERO] = 1'b1;
		end else begin
			out_d[bfm_pkg::BALL_IO_CHIP_SELECT_ZERO] =
				general_io_out[bfm_pkg::GPIO_SEVENTEEN];
			oe_d[bfm_pkg::BALL_IO_CHIP_SELECT_ZERO] = general_io_oe[bfm_pkg::GPIO_SEVENTEEN];
			gpio_in_d[bfm_pkg::GPIO_SEVENTEEN] = sync2_q[bfm_pkg::BALL_IO_CHIP_SELECT_ZERO];
		end
		// printer port group; balls without a video bit keep panel data
		case (grp)
			bfm_pkg::GRP_PRINTER: begin
				out_d[bfm_pkg::BALL_PD7] = printer_data_out[1];
				out_d[bfm_pkg::BALL_PD6] = printer_data_out[0];
				oe_d[bfm_pkg::BALL_PD7] = printer_data_oe;
				oe_d[bfm_pkg::BALL_PD6] = printer_data_oe;
				pd_in_d = {sync2_q[bfm_pkg::BALL_PD7], sync2_q[bfm_pkg::BALL_PD6]};
				busy_d = sync2_q[bfm_pkg::BALL_BUSY];
				ack_d = ~sync2_q[bfm_pkg::BALL_ACK];
				out_d[bfm_pkg::BALL_SELIN] = ~printer_select_in_out;
				out_d[bfm_pkg::BALL_INIT] = ~printer_init_out;
				oe_d[bfm_pkg::BALL_SELIN] = 1'b1;
				oe_d[bfm_pkg::BALL_INIT] = 1'b1;
			end
			bfm_pkg::GRP_PANEL, bfm_pkg::GRP_VIDEO: begin
				out_d[bfm_pkg::BALL_PD7] = flat_panel_data[13];
				out_d[bfm_pkg::BALL_SELIN] = flat_panel_data[16];
				if (grp == bfm_pkg::GRP_VIDEO) begin
					out_d[bfm_pkg::BALL_PD6] = video_out_port_data[0];
					out_d[bfm_pkg::BALL_BUSY] = video_out_port_data[2];
					out_d[bfm_pkg::BALL_ACK] = video_out_port_clock;
					out_d[bfm_pkg::BALL_INIT] = video_out_port_data[4];
				end else begin
					out_d[bfm_pkg::BALL_PD6] = flat_panel_data[1];
					out_d[bfm_pkg::BALL_BUSY] = flat_panel_data[3];
					out_d[bfm_pkg::BALL_ACK] = flat_panel_data_clock;
					out_d[bfm_pkg::BALL_INIT] = flat_panel_data[5];
				end
				oe_d[bfm_pkg::BALL_INIT:bfm_pkg::BALL_PD7] = '1;
			end
			bfm_pkg::GRP_MONITOR: begin
				out_d[bfm_pkg::BALL_PD7] = monitor_addr_data[7];
				out_d[bfm_pkg::BALL_PD6] = monitor_addr_data[6];
				out_d[bfm_pkg::BALL_BUSY] = ~monitor_byte_enable[1];
				out_d[bfm_pkg::BALL_ACK] = monitor_bus_clock;
				out_d[bfm_pkg::BALL_SELIN] = ~monitor_initiator_ready;
				out_d[bfm_pkg::BALL_INIT] = monitor_sys_mgmt_irq_out;
				oe_d[bfm_pkg::BALL_INIT:bfm_pkg::BALL_PD7] = '1;
			end
			default: begin
				oe_d[bfm_pkg::BALL_INIT:bfm_pkg::BALL_PD7] = '0;
			end
		endcase
		// general_io_ten ball: gpio, serial 2, disk channel 1 or test output
		case (uart_sel)
			2'h0: begin
				out_d[bfm_pkg::BALL_GENERAL_IO_TEN] =
					general_io_out[bfm_pkg::GPIO_TEN];
				oe_d[bfm_pkg::BALL_GENERAL_IO_TEN] = general_io_oe[bfm_pkg::GPIO_TEN];
				gpio_in_d[bfm_pkg::GPIO_TEN] = sync2_q[bfm_pkg::BALL_GENERAL_IO_TEN];
			end
			2'h2: begin
				dsr_d = ~sync2_q[bfm_pkg::BALL_GENERAL_IO_TEN];
			end
			2'h1: begin
				iordy_d = sync2_q[bfm_pkg::BALL_GENERAL_IO_TEN];
			end
			default: begin
				out_d[bfm_pkg::BALL_GENERAL_IO_TEN] = sdram_test_out_one;
				oe_d[bfm_pkg::BALL_GENERAL_IO_TEN] = 1'b1;
			end
		endcase
		// both owners stay live; the bus phase picks the driver
		out_d[bfm_pkg::BALL_CYCLE] = bus_phase_pci ? pci_ad_out
			: isa_data_out;
		oe_d[bfm_pkg::BALL_CYCLE] = bus_phase_pci ? pci_ad_oe : isa_data_oe;
		// strap ball only drives the clock once reset is gone
		out_d[bfm_pkg::BALL_PCI_CLOCK_OUT_ZERO] = pci_clock_out_zero;
		oe_d[bfm_pkg::BALL_PCI_CLOCK_OUT_ZERO] = ~reset;
	end

	// cycle-muxed input reaches both owners unconditionally
	always_comb begin
		pci_in_d = sync2_q[bfm_pkg::BALL_CYCLE];
		isa_in_d = sync2_q[bfm_pkg::BALL_CYCLE];
	end

	// registered ball drive and function inputs
	always_ff @(posedge mclk) begin
		if (reset) begin
			out_q <= '0;
			oe_q <= '0;
			gpio_in_q <= '0;
			pd_in_q <= '0;
			busy_q <= 1'b0;
			ack_q <= 1'b0;
			dsr_q <= 1'b0;
			iordy_q <= 1'b0;
			pci_in_q <= 1'b0;
			isa_in_q <= 1'b0;
		end else begin
			out_q <= out_d;
			oe_q <= oe_d;
			gpio_in_q <= gpio_in_d;
			pd_in_q <= pd_in_d;
			busy_q <= busy_d;
			ack_q <= ack_d;
			dsr_q <= dsr_d;
			iordy_q <= iordy_d;
			pci_in_q <= pci_in_d;
			isa_in_q <= isa_in_d;
		end
	end

	assign ball_out = out_q;
	assign ball_oe = oe_q;
	assign pullup_en = pullup_q;
	assign fast_bus_monitor_strap = strap_q;
	assign general_io_in = gpio_in_q;
	assign printer_data_in = pd_in_q;
	assign printer_busy_in = busy_q;
	assign printer_ack_in = ack_q;
	assign uart2_set_ready_in = dsr_q;
	assign disk_chan1_ready_in = iordy_q;
	assign pci_ad_in = pci_in_q;
	assign isa_data_in = isa_in_q;
endmodule // bfm_ball_mux
`default_nettype wire

//--- common/bfm_pkg.sv
// constants for the ball function multiplexer
package bfm_pkg;
	// ball_function_select_reg bit positions
	localparam int unsigned SEL_GPIO_STROBE = 21; // strobe ball to gpio
	localparam int unsigned SEL_FLASH_STROBE = 2; // strobe ball to flash disk
	localparam int unsigned SEL_FLASH_CS = 7; // cs ball to flash disk
	localparam int unsigned SEL_IO_CHIP_SELECT_ZERO = 5; // cs ball to io chip select 0
	localparam int unsigned SEL_FLAT_PANEL = 23; // flat panel group
	localparam int unsigned SEL_VIDEO_OUT = 15; // video out instead of panel
	localparam int unsigned SEL_MONITOR = 27; // fast bus monitor outputs
	localparam int unsigned SEL_UART2 = 18; // serial port 2 group
	localparam int unsigned SEL_DISK_CHAN1 = 8; // ide channel 1 group

	// ball indices on the pad vectors
	localparam int unsigned BALL_WR_STROBE = 0;
	localparam int unsigned BALL_FLASH_CS = 1;
	localparam int unsigned BALL_IO_CHIP_SELECT_ZERO = 2;
	localparam int unsigned BALL_PD7 = 3;
	localparam int unsigned BALL_PD6 = 4;
	localparam int unsigned BALL_BUSY = 5;
	localparam int unsigned BALL_ACK = 6;
	localparam int unsigned BALL_SELIN = 7;
	localparam int unsigned BALL_INIT = 8;
	localparam int unsigned BALL_GENERAL_IO_TEN = 9;
	localparam int unsigned BALL_CYCLE = 10;
	localparam int unsigned BALL_PCI_CLOCK_OUT_ZERO = 11;
	localparam int unsigned NUM_BALLS = 12;

	// general purpose io indices
	localparam int unsigned GPIO_FIFTEEN = 0;
	localparam int unsigned GPIO_TWENTY = 1;
	localparam int unsigned GPIO_SEVENTEEN = 2;
	localparam int unsigned GPIO_TEN = 3;
	localparam int unsigned NUM_GPIO = 4;

	// reset values
	localparam logic [NUM_GPIO-1:0] PULLUP_RESET = 4'hf;
	localparam logic STRAP_RESET = 1'h0;

	// function owning the parallel port ball group
	typedef enum logic [3:0] {
		GRP_PRINTER = 4'h1,
		GRP_PANEL = 4'h2,
		GRP_VIDEO = 4'h4,
		GRP_MONITOR = 4'h8
	} bfm_group_type;
endpackage

//--- sim/bfm_ball_mux_chk.sv
// checker for the ball function multiplexer ports
`timescale 1ns/1ps
`default_nettype none
module bfm_ball_mux_chk (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// configuration
	input wire logic [31:0] ball_function_select_reg,
	input wire logic pullup_wr_en,
	input wire logic [3:0] pullup_wr_data,
	input wire logic [3:0] pullup_en,
	input wire logic fast_bus_monitor_strap,
	// balls
	input wire logic [11:0] ball_in,
	input wire logic [11:0] ball_out,
	input wire logic [11:0] ball_oe,
	// functions
	input wire logic isa_io_write_strobe,
	input wire logic flash_disk_write_strobe,
	input wire logic [17:0] flat_panel_data,
	input wire logic [7:0] monitor_addr_data,
	input wire logic uart2_set_ready_in,
	input wire logic disk_chan1_ready_in,
	input wire logic bus_phase_pci,
	input wire logic pci_ad_out,
	input wire logic pci_ad_oe,
	input wire logic isa_data_out,
	input wire logic isa_data_oe
);
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	wire [31:0] s = ball_function_select_reg; // short name for selects
	// monitor owns the printer group only while the panel is off
	wire mon = !s[23] && (s[27] || fast_bus_monitor_strap);

	strobe_isa_a: assert property (!s[21] && !s[2] |=>
		ball_oe[0] && ball_out[0] == !$past(isa_io_write_strobe))
		else $error("isa write strobe missing on its ball");
	strobe_flash_a: assert property (!s[21] && s[2] |=>
		ball_oe[0] && ball_out[0] == !$past(flash_disk_write_strobe))
		else $error("flash write strobe missing on its ball");
	strobe_undef_a: assert property (s[21] && !s[2] |=>
		!ball_oe[0]) else $error("undefined strobe code drives ball");
	panel_cs_a: assert property (s[23] && !s[15] |=>
		ball_oe[1] && ball_out[1] == $past(flat_panel_data[0]))
		else $error("panel data bit not on chip select ball");
	monitor_ad_a: assert property (mon |=>
		ball_oe[3] && ball_out[3] == $past(monitor_addr_data[7]))
		else $error("monitor data not on printer ball");
	// the synchroniser gives three edges from ball to function input
	uart_in_a: assert property ((s[18] && !s[8])[*4] |->
		uart2_set_ready_in == !$past(ball_in[9], 3))
		else $error("uart ready input does not follow ball");
	chan1_in_a: assert property ((!s[18] && s[8])[*4] |->
		disk_chan1_ready_in == $past(ball_in[9], 3))
		else $error("disk ready input does not follow ball");
	cycle_mux_a: assert property (
		(bus_phase_pci ? pci_ad_oe : isa_data_oe) |=> ball_oe[10] &&
		ball_out[10] == $past(bus_phase_pci ? pci_ad_out : isa_data_out))
		else $error("cycle shared ball shows wrong owner");
	reset_idle_a: assert property (disable iff (1'b0) reset |=>
		ball_oe == 12'h000 && pullup_en == 4'hf)
		else $error("balls driven or pulls off in reset");
	pullup_wr_a: assert property (pullup_wr_en |=>
		pullup_en == $past(pullup_wr_data))
		else $error("pull-up write not taken");

	strap_cov: cover property (mon && fast_bus_monitor_strap);
	undef_cov: cover property (s[21] && !s[2]);
	uart_cov: cover property ((s[18] && !s[8])[*4]);
endmodule // bfm_ball_mux_chk
bind bfm_ball_mux bfm_ball_mux_chk chk (.mclk, .reset,
	.ball_function_select_reg, .pullup_wr_en, .pullup_wr_data, .pullup_en,
	.fast_bus_monitor_strap, .ball_in, .ball_out, .ball_oe,
	.isa_io_write_strobe, .flash_disk_write_strobe, .flat_panel_data,
	.monitor_addr_data, .uart2_set_ready_in, .disk_chan1_ready_in,
	.bus_phase_pci, .pci_ad_out, .pci_ad_oe, .isa_data_out, .isa_data_oe);
`default_nettype wire

//--- sim/bfm_board_model.sv
// board peripherals, pulls and strap resistor on the balls
`timescale 1ns/1ps
`default_nettype none
module bfm_board_model (
	// clock
	input wire logic mclk,
	// device side
	input wire logic [11:0] ball_out,
	input wire logic [11:0] ball_oe,
	input wire logic [3:0] pullup_en,
	// peripheral drive chosen by the bench
	input wire logic [11:0] ext_drv,
	input wire logic [11:0] ext_en,
	input wire logic strap_hi,
	// resolved levels
	output logic [11:0] ball_in
);
	logic [11:0] flt_q; // undriven balls wander, never hold a value
	always_ff @(posedge mclk) begin
		flt_q <= ~ball_in;
	end
	// device wins, then a peripheral, then pulls, else wander
	always_comb begin
		ball_in = flt_q;
		if (pullup_en[0]) ball_in[0] = 1'b1;
		if (pullup_en[1]) ball_in[1] = 1'b1;
		if (pullup_en[2]) ball_in[2] = 1'b1;
		if (pullup_en[3]) ball_in[9] = 1'b1;
		ball_in[11] = strap_hi; // weak pull-down or strap
		ball_in = (ball_oe & ball_out) | (~ball_oe & ext_en & ext_drv) |
			(~ball_oe & ~ext_en & ball_in);
	end
endmodule // bfm_board_model
`default_nettype wire

//--- sim/ball_function_multiplexer_tb.sv
// random bench for the ball function multiplexer with a ball model
`timescale 1ns/1ps
`default_nettype none
module ball_function_multiplexer_tb;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic [31:0] ball_function_select_reg;
	logic pullup_wr_en;
	logic [3:0] pullup_wr_data, pullup_en, general_io_in;
	logic isa_io_write_strobe, flash_disk_write_strobe;
	logic flash_disk_chip_select, io_chip_select_zero;
	logic [3:0] general_io_out, general_io_oe, monitor_byte_enable;
	logic [17:0] flat_panel_data;
	logic flat_panel_data_clock, video_out_port_clock;
	logic [7:0] video_out_port_data, monitor_addr_data;
	logic monitor_initiator_ready, monitor_bus_clock;
	logic monitor_sys_mgmt_irq_out, printer_data_oe;
	logic [1:0] printer_data_out, printer_data_in;
	logic printer_select_in_out, printer_init_out, sdram_test_out_one;
	logic bus_phase_pci, pci_ad_out, pci_ad_oe, isa_data_out;
	logic isa_data_oe, pci_clock_out_zero, fast_bus_monitor_strap;
	logic uart2_set_ready_in, disk_chan1_ready_in, printer_busy_in;
	logic printer_ack_in, pci_ad_in, isa_data_in;
	logic [11:0] ball_in, ball_out, ball_oe, ext_drv, ext_en, eo, ev;
	logic [3:0] exp_pu; // expected pull-up enables
	logic [35:0] hist; // ball levels at the last three edges, newest low
	logic strap_hi = 1'b1;
	logic [127:0] r;
	integer seed = 32'he251;
	int errors = 0;
	int checks_done = 0;

	always #12.5 mclk = ~mclk; // 40 MHz

	bfm_ball_mux dut (.*);

	// same sampling as the synchroniser: function inputs lag three edges
	always @(posedge mclk) begin
		hist <= {hist[23:0], ball_in};
	end
	bfm_board_model board (.mclk(mclk), .ball_out(ball_out),
		.ball_oe(ball_oe), .pullup_en(pullup_en), .ext_drv(ext_drv),
		.ext_en(ext_en), .strap_hi(strap_hi), .ball_in(ball_in));

	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// new random inputs; selects stay put for eight cycles
	task automatic drive(input int i);
		r = {$random(seed), $random(seed), $random(seed), $random(seed)};
		{isa_io_write_strobe, flash_disk_write_strobe,
			flash_disk_chip_select, io_chip_select_zero, general_io_out,
			general_io_oe, flat_panel_data, flat_panel_data_clock,
			video_out_port_clock, video_out_port_data, monitor_addr_data,
			monitor_byte_enable, monitor_initiator_ready, monitor_bus_clock,
			monitor_sys_mgmt_irq_out, printer_data_out, printer_data_oe,
			printer_select_in_out, printer_init_out, sdram_test_out_one,
			bus_phase_pci, pci_ad_out, pci_ad_oe, isa_data_out, isa_data_oe,
			pci_clock_out_zero} = r[66:0];
		ext_drv = r[78:67];
		// no peripheral drives ball 11; only the strap resistor or the device itself sets it
		ext_en = r[90:79] & 12'h7ff;
		pullup_wr_data = r[99:96];
		pullup_wr_en = (r[102:100] == 3'h0) && !reset;
		if (i % 8 == 0) ball_function_select_reg = r[127:96] ^ r[31:0];
	endtask

	// expected ball drive one edge after the inputs
	task automatic model();
		logic [31:0] s;
		logic mon, pnl;
		s = ball_function_select_reg;
		mon = !s[23] && (s[27] || strap_hi);
		pnl = s[23] && !s[15];
		{eo[0], ev[0]} = s[21] ? (s[2] ? {general_io_oe[0],
			general_io_out[0]} : 2'b00) : {1'b1, s[2] ?
			~flash_disk_write_strobe : ~isa_io_write_strobe};
		{eo[1], ev[1]} = pnl ? {1'b1, flat_panel_data[0]} : s[7] ?
			{1'b1, ~flash_disk_chip_select} :
			{general_io_oe[1], general_io_out[1]};
		{eo[2], ev[2]} = pnl ? {1'b1, flat_panel_data_clock} : s[5] ?
			{1'b1, ~io_chip_select_zero} :
			{general_io_oe[2], general_io_out[2]};
		{eo[3], ev[3]} = mon ? {1'b1, monitor_addr_data[7]} : s[23] ?
			{1'b1, flat_panel_data[13]} : {printer_data_oe, printer_data_out[1]};
		{eo[4], ev[4]} = mon ? {1'b1, monitor_addr_data[6]} : s[23] ?
			{1'b1, s[15] ? video_out_port_data[0] : flat_panel_data[1]} :
			{printer_data_oe, printer_data_out[0]};
		{eo[5], ev[5]} = mon ? {1'b1, ~monitor_byte_enable[1]} : s[23] ?
			{1'b1, s[15] ? video_out_port_data[2] : flat_panel_data[3]} : 2'b00;
		{eo[6], ev[6]} = mon ? {1'b1, monitor_bus_clock} : s[23] ?
			{1'b1, s[15] ? video_out_port_clock : flat_panel_data_clock} : 2'b00;
		{eo[7], ev[7]} = mon ? {1'b1, ~monitor_initiator_ready} :
			{1'b1, s[23] ? flat_panel_data[16] : ~printer_select_in_out};
		{eo[8], ev[8]} = mon ? {1'b1, monitor_sys_mgmt_irq_out} : s[23] ?
			{1'b1, s[15] ? video_out_port_data[4] : flat_panel_data[5]} :
			{1'b1, ~printer_init_out};
		{eo[9], ev[9]} = (s[18] == s[8]) ? (s[8] ? {1'b1, sdram_test_out_one} :
			{general_io_oe[3], general_io_out[3]}) : 2'b00;
		{eo[10], ev[10]} = bus_phase_pci ? {pci_ad_oe, pci_ad_out} :
			{isa_data_oe, isa_data_out};
		{eo[11], ev[11]} = {1'b1, pci_clock_out_zero};
		if (pullup_wr_en) exp_pu = pullup_wr_data;
	endtask

	task automatic step(input int i);
		logic [31:0] s;
		logic [11:0] h;
		logic pg, pn;
		s = ball_function_select_reg;
		h = hist[35:24];
		pg = !s[23] && !(s[27] || strap_hi);
		pn = s[23] && !s[15];
		if (i > 0) begin
			chk("printer inputs", 32'({printer_data_in, printer_busy_in,
				printer_ack_in}), pg ? 32'({h[3], h[4], h[5], ~h[6]}) :
				32'h0);
			chk("cycle inputs", 32'({pci_ad_in, isa_data_in}),
				32'({h[10], h[10]}));
			chk("gpio inputs", 32'(general_io_in), 32'({
				(!s[18] && !s[8]) & h[9], (!pn && !s[5]) & h[2],
				(!pn && !s[7]) & h[1], (s[21] && s[2]) & h[0]}));
			chk("ready inputs", 32'({uart2_set_ready_in,
				disk_chan1_ready_in}), 32'({(s[18] && !s[8]) & ~h[9],
				(!s[18] && s[8]) & h[9]}));
			chk("ball_oe", 32'(ball_oe), 32'(eo));
			chk("ball_out", 32'(ball_out & eo), 32'(ev & eo));
			chk("pullup_en", 32'(pullup_en), 32'(exp_pu));
		end
		// unselected function inputs must read inactive once settled
		if (i % 8 >= 4) chk("unselected inputs", 32'({
			uart2_set_ready_in & ~(s[18] & ~s[8]),
			disk_chan1_ready_in & ~(~s[18] & s[8]),
			general_io_in[0] & ~(s[21] & s[2])}), 32'h0);
		drive(i);
		model();
	endtask

	task automatic do_reset(input logic strap);
		reset = 1'b1;
		pullup_wr_en = 1'b0;
		strap_hi = strap;
		repeat (20) @(negedge mclk);
		reset = 1'b0;
		exp_pu = 4'hf;
		chk("strap", 32'(fast_bus_monitor_strap), 32'(strap));
	endtask

	task automatic end_sim();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// strap high first, then a second reset with the strap low
	initial begin
		drive(0);
		for (int p = 0; p < 2; p++) begin
			do_reset(p == 0);
			for (int i = 0; i < 400; i++) begin
				@(negedge mclk);
				step(i);
			end
		end
		end_sim();
	end
endmodule // ball_function_multiplexer_tb
`default_nettype wire
